// ==== dv/gpx_pin_world.sv ====
/*
 * Board model around the pins: external drivers, pulls, floating
 * pins and the pulled-up interrupt wire. Assumes bench owns ext_*.
 */
`timescale 1ns/10ps
module gpx_pin_world
   import gpx_pkg::*;
(
   // Clock
   input wire logic          clk,
   // From the core
   input wire logic [PW-1:0] port_o,
   input wire logic [PW-1:0] port_oe,
   input wire logic [PW-1:0] port_pull_en,
   input wire logic [PW-1:0] port_pull_up,
   input wire logic          int_n_o,
   input wire logic          int_n_oe,
   // From the bench
   input wire logic [PW-1:0] ext_val,
   input wire logic [PW-1:0] ext_drv,
   // Resolved wires
   output logic [PW-1:0]     port_i,
   output logic              int_line
);
   // Floating pins toggle so a stale level never passes for data
   logic [PW-1:0] flip_reg = 16'h5a5a;
   always @(posedge clk) begin
      flip_reg <= ~flip_reg;
   end

   // Core driver wins, then board driver, then pull, else float
   always_comb begin
      for (int i = 0; i < PW; i++) begin
         port_i[i] = port_oe[i] ? port_o[i] :
                     ext_drv[i] ? ext_val[i] :
                     port_pull_en[i] ? port_pull_up[i] :
                     flip_reg[i];
      end
   end

   // Open-drain interrupt with board pull-up
   assign int_line = int_n_oe ? int_n_o : 1'b1;
endmodule // gpx_pin_world

// ==== dv/gpx_top_assertions.sv ====
/*
 * Port-level checker for the GPIO expander core.
 * Assumes one hclk domain and hresetn asynchronous, active low.
 */
`timescale 1ns/10ps
module gpx_top_chk
   import gpx_pkg::*;
(
   // Clock and reset
   input wire logic              hclk,
   input wire logic              hresetn,
   // Bus
   input wire logic              hsel,
   input wire logic [31:0]       haddr,
   input wire logic [1:0]        htrans,
   input wire logic              hwrite,
   input wire logic              hready,
   input wire logic              hreadyout,
   input wire logic              hresp,
   // Pins
   input wire logic [PW-1:0]     port_i,
   input wire logic [PW-1:0]     port_o,
   input wire logic [PW-1:0]     port_oe,
   input wire logic [PW-1:0]     port_pull_en,
   input wire logic [PW-1:0]     port_pull_up,
   input wire logic [PW*DSW-1:0] port_drive,
   input wire logic              int_n_o,
   input wire logic              int_n_oe
);
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   logic wr_take; // Write address phase accepted
   logic rd_in;   // Read of the input register accepted
   assign wr_take = hsel & htrans[1] & hready & hwrite;
   assign rd_in   = hsel & htrans[1] & hready & !hwrite &
                    (haddr[7:0] == A_INPUT);

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Pad change is seen three edges after the write is taken
   sequence wr_launch;
      $past(wr_take, 3);
   endsequence
   // Pins quiet long enough for the sync pipe to drain
   sequence pins_quiet;
      $stable(port_i) [*4];
   endsequence

   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   a_int_low_only: assert property (int_n_o == 1'b0)
      else $error("interrupt pin drives high");
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus slave stalled or erred");
   a_reset_inputs: assert property ($rose(hresetn) |->
      port_oe == '0 ##1 port_oe == '0)
      else $error("pin driven right after reset");
   a_reset_masked: assert property ($rose(hresetn) |->
      !int_n_oe [*3])
      else $error("interrupt right after reset");
   a_out_hold: assert property (
      $changed(port_o) && $past(hresetn, 2) |-> wr_launch)
      else $error("outputs moved unwritten");
   a_drive_hold: assert property (
      $changed(port_drive) && $past(hresetn, 2) |-> wr_launch)
      else $error("drive moved unwritten");
   a_pull_hold: assert property (($changed(port_pull_en) ||
      $changed(port_pull_up)) && $past(hresetn, 2) |-> wr_launch)
      else $error("pulls moved unwritten");
   a_read_clears: assert property (
      pins_quiet ##0 rd_in |-> ##[1:4] !int_n_oe)
      else $error("read left interrupt");
endmodule // gpx_top_chk

// ==== dv/gpx_top_bench.sv ====
/*
 * Self-checking bench for the GPIO expander core over AHB-Lite.
 * Assumes the core answers with zero wait states, hready looped.
 */
`timescale 1ns/10ps
module gpx_top_bench;
   import gpx_pkg::*;
   logic              hclk, hresetn, hsel, hwrite;
   logic [1:0]        htrans;
   logic [2:0]        hsize;
   logic [31:0]       haddr, hwdata, hrdata, rd;
   logic              hreadyout, hresp, int_n_o, int_n_oe, int_line;
   logic [PW-1:0]     port_i, port_o, port_oe, port_pull_en;
   logic [PW-1:0]     port_pull_up, ext_val, ext_drv;
   logic [PW*DSW-1:0] port_drive;
   int                mismatches, checks_done;
   logic [7:0]        ra [11];   // Reset table addresses
   logic [31:0]       rv [11];   // Reset table values

   gpx_top dut (.hready(hreadyout), .addr_strap_bit0(1'b1),
      .addr_strap_bit1(1'b0), .addr_strap_bit2(1'b1), .*);
   gpx_pin_world world (.clk(hclk), .*);

   always #50 hclk = ~hclk;

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task chk(input string nm, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task put(input logic [7:0] a, input logic [31:0] d);
      ahb_xfer(1'b1, a, d);
   endtask
   task peek(input logic [7:0] a, input string nm,
             input logic [31:0] exp);
      ahb_xfer(1'b0, a, '0);
      chk(nm, rd, exp);
   endtask
   // One single transfer; waits on hready, never on a fixed count
   task ahb_xfer(input logic wr, input logic [7:0] a,
                 input logic [31:0] d);
      int n;
      n = 0;
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 40);
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 40);
      rd = hrdata;
      if (n >= 40) mismatches++;
   endtask
   task pins(input logic [PW-1:0] v);
      ext_val <= v;
      repeat (6) @(posedge hclk);
   endtask
   task wait_int(input logic lvl);
      for (int n = 0; n < 20 && int_line !== lvl; n++) begin
         @(posedge hclk);
      end
   endtask
   task wrap_up;
      $display("Counts: %0d checks, %0d mismatches", checks_done,
               mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Watchdog, under two hundred cycles are expected
   // ---------------------------------------------------------------
   initial begin
      repeat (3000) @(posedge hclk);
      mismatches++;
      $display("Watchdog expired");
      wrap_up;
   end

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0;
      htrans = 2'h0; hsize = 3'h2; haddr = '0; hwdata = '0;
      ext_val = '0; ext_drv = 16'hffff; mismatches = 0; checks_done = 0;
      ra = '{A_OUTPUT, A_POLINV, A_CONFIG, A_DRIVE, A_LATCH, A_PULLEN,
             A_PULLSL, A_MASK, A_OUTCFG, A_TADDR, 8'h30};
      rv = '{{16'h0, RST_OUT}, 32'h0, {16'h0, RST_CONFIG}, RST_DRIVE,
             32'h0, 32'h0, {16'h0, RST_PULLSL}, {16'h0, RST_MASK},
             32'h0, {25'h0, TADDR_HI, 3'b101}, 32'h0};
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      // Reset values, straps and an unmapped word
      for (int i = 0; i < 11; i++) begin
         peek(ra[i], "reset reg", rv[i]);
      end
      chk("oe at reset", 32'(port_oe), 32'h0);
      chk("int at reset", 32'(int_line), 32'h1);
      put(8'h30, 32'hffff_ffff);
      peek(8'h30, "unmapped", 32'h0);
      $display("reset test done");
      // Outputs, bank open-drain, drive and pulls
      put(A_CONFIG, 32'h0);
      put(A_OUTPUT, 32'ha53c);
      repeat (2) @(posedge hclk);
      chk("out", 32'(port_o), 32'ha53c);
      chk("oe", 32'(port_oe), 32'hffff);
      put(A_OUTCFG, 32'h2);
      repeat (2) @(posedge hclk);
      chk("oe od", 32'(port_oe), 32'h5aff);
      chk("out hold", 32'(port_o), 32'ha53c);
      put(A_DRIVE, 32'h1b1b_e4e4);
      put(A_PULLEN, 32'h00ff);
      put(A_PULLSL, 32'h0f0f);
      repeat (2) @(posedge hclk);
      chk("drive", port_drive, 32'h1b1b_e4e4);
      chk("pull en", 32'(port_pull_en), 32'h00ff);
      chk("pull up", 32'(port_pull_up), 32'h0f0f);
      put(A_CONFIG, 32'hffff);
      repeat (2) @(posedge hclk);
      chk("oe off", 32'(port_oe), 32'h0);
      $display("output test done");
      // Interrupts: masked, raised, serviced, hidden, cleared
      put(A_STATUS, 32'hffff);
      put(A_MASK, 32'hfefe);
      pins(16'h0002);
      chk("masked int", 32'(int_line), 32'h1);
      peek(A_STATUS, "masked status", 32'h0);
      pins(16'h0102);
      wait_int(1'b0);
      chk("int", 32'(int_line), 32'h0);
      peek(A_STATUS, "status", 32'h0100);
      peek(A_INPUT, "input", 32'h0102);
      repeat (4) @(posedge hclk);
      chk("int released", 32'(int_line), 32'h1);
      put(A_POLINV, 32'h00ff);
      peek(A_INPUT, "input inv", 32'h01fd);
      put(A_POLINV, 32'h0);
      pins(16'h0103);
      wait_int(1'b0);
      chk("int bit0", 32'(int_line), 32'h0);
      put(A_MASK, 32'hffff);
      wait_int(1'b1);
      chk("int hidden", 32'(int_line), 32'h1);
      peek(A_STATUS, "sticky", 32'h0001);
      put(A_STATUS, 32'h0001);
      peek(A_STATUS, "cleared", 32'h0);
      $display("interrupt test done");
      // Latched input holds its first change until read
      put(A_LATCH, 32'h0004);
      pins(16'h0107);
      pins(16'h0103);
      peek(A_INPUT, "latched", 32'h0107);
      repeat (3) @(posedge hclk);
      peek(A_INPUT, "released", 32'h0103);
      $display("latch test done");
      wrap_up;
   end
endmodule // gpx_top_bench

bind gpx_top gpx_top_chk u_chk (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .port_i(port_i), .port_o(port_o), .port_oe(port_oe),
   .port_pull_en(port_pull_en), .port_pull_up(port_pull_up),
   .port_drive(port_drive), .int_n_o(int_n_o), .int_n_oe(int_n_oe));

// ==== hw/gpx_pad.sv ====
/*
 * Pad stage: registers pin drive, enable, pulls and strength.
 * Assumes the pad cell resolves the wire from enable and level.
 */
`timescale 1ns/10ps
module gpx_pad
   import gpx_pkg::*;
(
   // Control bundle
   gpx_pad_if.pad              pc,
   // Pins
   output logic [PW-1:0]      port_o,
   output logic [PW-1:0]      port_oe,
   output logic [PW-1:0]      port_pull_en,
   output logic [PW-1:0]      port_pull_up,
   output logic [PW*DSW-1:0]  port_drive
);
   logic [PW-1:0] od_bit; // Open-drain per bit, from bank

   // Spread bank setting to its eight bits
   always_comb begin
      for (int i = 0; i < PW; i++) begin
         od_bit[i] = pc.od_bank[i / BW];
      end
   end

   // ---------------------------------------------------------------
   // Registered pad controls
   // ---------------------------------------------------------------
   always_ff @(posedge pc.clk or negedge pc.rstn) begin
      if (!pc.rstn) begin
         // All pins inputs, driver off
         port_o       <= '0;
         port_oe      <= '0;
         port_pull_en <= '0;
         port_pull_up <= '0;
         port_drive   <= '0;
      end else begin
         port_o       <= pc.out_val;
         // Open-drain drives only lows
         port_oe      <= ~pc.dir_in & ~(od_bit & pc.out_val);
         port_pull_en <= pc.pull_en;
         port_pull_up <= pc.pull_sel;
         port_drive   <= pc.drive;
      end
   end
endmodule // gpx_pad

// ==== hw/gpx_pad_if.sv ====
/*
 * Pad control bundle between the register core and the pad stage.
 * Assumes one clock and one reset shared by both ends.
 */
`timescale 1ns/10ps
interface gpx_pad_if;
   import gpx_pkg::*;
   logic              clk;      // Core clock
   logic              rstn;     // Core reset, active low
   logic [PW-1:0]     out_val;  // Output latch
   logic [PW-1:0]     dir_in;   // 1 = input
   logic [PW-1:0]     pull_en;  // Pull enable
   logic [PW-1:0]     pull_sel; // 1 = pull-up
   logic [NB-1:0]     od_bank;  // 1 = open-drain bank
   logic [PW*DSW-1:0] drive;    // Drive codes
   modport ctl (output clk, rstn, out_val, dir_in, pull_en,
                pull_sel, od_bank, drive);
   modport pad (input clk, rstn, out_val, dir_in, pull_en,
                pull_sel, od_bank, drive);
endinterface // gpx_pad_if

// ==== hw/gpx_pkg.sv ====
/*
 * Shared constants and types for the 16-bit GPIO expander.
 * Assumes a single AHB-Lite slave select and word-only transfers.
 */
package gpx_pkg;

   // ---------------------------------------------------------------
   // Geometry
   // ---------------------------------------------------------------
   localparam int PW     = 16;  // Port bits
   localparam int BW     = 8;   // Bits per bank
   localparam int NB     = 2;   // Banks
   localparam int DSW    = 2;   // Drive code width (four levels)
   localparam int ADDR_W = 8;   // Decoded address bits
   localparam int SAW    = 3;   // Strap bits
   localparam int TAW    = 7;   // Bus target address width

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] A_INPUT  = 8'h00;
   localparam logic [7:0] A_OUTPUT = 8'h04;
   localparam logic [7:0] A_POLINV = 8'h08;
   localparam logic [7:0] A_CONFIG = 8'h0c;
   localparam logic [7:0] A_DRIVE  = 8'h10;
   localparam logic [7:0] A_LATCH  = 8'h14;
   localparam logic [7:0] A_PULLEN = 8'h18;
   localparam logic [7:0] A_PULLSL = 8'h1c;
   localparam logic [7:0] A_MASK   = 8'h20;
   localparam logic [7:0] A_STATUS = 8'h24;
   localparam logic [7:0] A_OUTCFG = 8'h28;
   localparam logic [7:0] A_TADDR  = 8'h2c;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [PW-1:0]     RST_OUT    = 16'hffff;
   localparam logic [PW-1:0]     RST_CONFIG = 16'hffff;
   localparam logic [PW-1:0]     RST_ZERO   = 16'h0000;
   localparam logic [PW-1:0]     RST_PULLSL = 16'hffff;
   localparam logic [PW-1:0]     RST_MASK   = 16'hffff;
   localparam logic [PW*DSW-1:0] RST_DRIVE  = 32'hffff_ffff;
   localparam logic [NB-1:0]     RST_OUTCFG = 2'h0;
   localparam logic [3:0]        TADDR_HI   = 4'h4; // Arbitrary

   // AHB transfer type bit that marks NONSEQ/SEQ
   localparam int HTRANS_ACT = 1;

   // Bus data-phase state, Gray along idle->read->write
   typedef enum logic [1:0] {
      GPX_IDLE = 2'b00,
      GPX_RD   = 2'b01,
      GPX_WR   = 2'b11
   } gpx_state_t;

endpackage

// ==== hw/gpx_sync.sv ====
/*
 * Two-flop synchroniser for a bus of levels.
 * Assumes the inputs are slow levels, not pulses.
 */
`timescale 1ns/10ps
module gpx_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rstn,
   // Levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg; // First stage, read only by q

   // ---------------------------------------------------------------
   // Two stages
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule // gpx_sync

// ==== hw/gpx_top.sv ====
/*
 * 16-bit GPIO expander core with AHB-Lite register slave.
 * Assumes one AHB-Lite master, single word transfers, pins and
 * straps asynchronous to hclk.
 */
// Local design decisions: the AHB-Lite interface to the registers and the address map.
// What this block does
// - Input differing from input register raises interrupt
// - All interrupt masks set after reset
// - Reset loads defaults and idles state machine
// - Three straps give low target address bits
// - All pins inputs, drivers off after reset
// - Latched input change held until read
// - Set mask bit blocks that input's interrupt
// - Status register shows which inputs interrupted
// - Per bank push-pull or open-drain outputs
// - Per bit drive strength, four levels
// - Per bit pull enable and up/down select
// - Two 8-bit banks, each full register set
// - Interrupt pin open-drain, low while pending
// - Outputs come from latch, hold until written
`timescale 1ns/10ps
module gpx_top
   import gpx_pkg::*;
(
   // Clock and reset
   input  wire logic             hclk,
   input  wire logic             hresetn,
   // AHB-Lite slave
   input  wire logic             hsel,
   input  wire logic [31:0]      haddr,
   input  wire logic [1:0]       htrans,
   input  wire logic             hwrite,
   input  wire logic [2:0]       hsize,
   input  wire logic [31:0]      hwdata,
   input  wire logic             hready,
   output logic      [31:0]      hrdata,
   output logic                  hreadyout,
   output logic                  hresp,
   // Port pins
   input  wire logic [PW-1:0]    port_i,
   output logic      [PW-1:0]    port_o,
   output logic      [PW-1:0]    port_oe,
   output logic      [PW-1:0]    port_pull_en,
   output logic      [PW-1:0]    port_pull_up,
   output logic [PW*DSW-1:0]     port_drive,
   // Address straps
   input  wire logic             addr_strap_bit0,
   input  wire logic             addr_strap_bit1,
   input  wire logic             addr_strap_bit2,
   // Interrupt pin, open-drain
   output logic                  int_n_o,
   output logic                  int_n_oe
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   gpx_state_t          st_reg;      // Data-phase state
   gpx_state_t          st_next;     // Next state
   logic [ADDR_W-1:0]   wa_reg;      // Write address of data phase
   logic                acc;         // Address phase taken
   logic                rd_acc;      // Read address phase taken
   logic                rd_in;       // Read of input register
   logic                wr;          // Write data phase
   logic [PW-1:0]       pin_s;       // Synchronised pins
   logic [SAW-1:0]      strap_s;     // Synchronised straps
   logic [PW-1:0]       in_reg;      // Input port register
   logic [PW-1:0]       in_next;
   logic [PW-1:0]       hold_reg;    // Latched change pending
   logic [PW-1:0]       hold_next;
   logic [PW-1:0]       out_reg;     // Output latch
   logic [PW-1:0]       pol_reg;     // Polarity inversion
   logic [PW-1:0]       cfg_reg;     // Direction, 1 = input
   logic [PW*DSW-1:0]   drv_reg;     // Drive codes
   logic [PW-1:0]       lat_reg;     // Input latch enables
   logic [PW-1:0]       pen_reg;     // Pull enables
   logic [PW-1:0]       psel_reg;    // Pull select
   logic [PW-1:0]       mask_reg;    // Interrupt masks
   logic [PW-1:0]       sts_reg;     // Interrupt status
   logic [PW-1:0]       sts_next;
   logic [PW-1:0]       diff;        // Pin differs from register
   logic [NB-1:0]       ocfg_reg;    // Open-drain per bank
   logic [TAW-1:0]      taddr_reg;   // Bus target address
   logic                taddr_done;  // Strap capture finished
   logic [1:0]          fill_reg;    // Synchroniser fill marks
   logic [31:0]         rdata_reg;   // Read data
   logic                irq;         // Pending, unmasked

   gpx_pad_if           pif ();      // Pad bundle

   // Address hit on a register offset
   function automatic logic hit(input logic [31:0] a,
                                input logic [7:0]  off);
      return a[ADDR_W-1:0] == off;
   endfunction

   // Zero-extend one bank pair into a bus word
   function automatic logic [31:0] ext16(input logic [PW-1:0] v);
      return {16'h0000, v};
   endfunction

   // ---------------------------------------------------------------
   // Synchronisers
   // ---------------------------------------------------------------
   // Pins and straps are asynchronous to hclk
   gpx_sync #(.W(PW)) u_pin_sync (
      .clk  (hclk),
      .rstn (hresetn),
      .d    (port_i),
      .q    (pin_s)
   );

   gpx_sync #(.W(SAW)) u_strap_sync (
      .clk  (hclk),
      .rstn (hresetn),
      .d    ({addr_strap_bit2, addr_strap_bit1, addr_strap_bit0}),
      .q    (strap_s)
   );

   // ---------------------------------------------------------------
   // AHB-Lite front end
   // ---------------------------------------------------------------
   // Never waits, never errors: one data cycle per transfer
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_reg;

   // Only NONSEQ/SEQ with hready take an address phase
   assign acc    = hsel & htrans[HTRANS_ACT] & hready;
   assign rd_acc = acc & ~hwrite;
   assign rd_in  = rd_acc & hit(haddr, A_INPUT);
   assign wr     = (st_reg == GPX_WR);

   // Next data-phase state
   always_comb begin
      st_next = GPX_IDLE;
      unique case (st_reg)
         GPX_IDLE,
         GPX_RD,
         GPX_WR: begin
            if (acc) begin
               st_next = hwrite ? GPX_WR : GPX_RD;
            end
         end
         default: begin
            st_next = GPX_IDLE; // Illegal code recovers
         end
      endcase
   end

   // State and write address; reset idles the machine
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= GPX_IDLE;
         wa_reg <= '0;
      end else begin
         st_reg <= st_next;
         if (acc) begin
            wa_reg <= haddr[ADDR_W-1:0];
         end
      end
   end

   // Read data is formed at the address phase, so it stands
   // registered through the whole data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_reg <= '0;
      end else if (rd_acc) begin
         unique case (1'b1)
            hit(haddr, A_INPUT):  rdata_reg <= ext16(in_reg ^ pol_reg);
            hit(haddr, A_OUTPUT): rdata_reg <= ext16(out_reg);
            hit(haddr, A_POLINV): rdata_reg <= ext16(pol_reg);
            hit(haddr, A_CONFIG): rdata_reg <= ext16(cfg_reg);
            hit(haddr, A_DRIVE):  rdata_reg <= drv_reg;
            hit(haddr, A_LATCH):  rdata_reg <= ext16(lat_reg);
            hit(haddr, A_PULLEN): rdata_reg <= ext16(pen_reg);
            hit(haddr, A_PULLSL): rdata_reg <= ext16(psel_reg);
            hit(haddr, A_MASK):   rdata_reg <= ext16(mask_reg);
            hit(haddr, A_STATUS): rdata_reg <= ext16(sts_reg);
            hit(haddr, A_OUTCFG): rdata_reg <= {30'h0, ocfg_reg};
            hit(haddr, A_TADDR):  rdata_reg <= {25'h0, taddr_reg};
            default:              rdata_reg <= '0; // Unmapped
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   // Each bank owns its byte of every 16-bit register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_reg  <= RST_OUT;
         pol_reg  <= RST_ZERO;
         cfg_reg  <= RST_CONFIG;
         lat_reg  <= RST_ZERO;
         pen_reg  <= RST_ZERO;
         psel_reg <= RST_PULLSL;
         mask_reg <= RST_MASK;
      end else if (wr) begin
         // Output latch changes only on a write
         if (hit({24'h0, wa_reg}, A_OUTPUT)) begin
            out_reg <= hwdata[PW-1:0];
         end
         if (hit({24'h0, wa_reg}, A_POLINV)) begin
            pol_reg <= hwdata[PW-1:0];
         end
         if (hit({24'h0, wa_reg}, A_CONFIG)) begin
            cfg_reg <= hwdata[PW-1:0];
         end
         if (hit({24'h0, wa_reg}, A_LATCH)) begin
            lat_reg <= hwdata[PW-1:0];
         end
         if (hit({24'h0, wa_reg}, A_PULLEN)) begin
            pen_reg <= hwdata[PW-1:0];
         end
         if (hit({24'h0, wa_reg}, A_PULLSL)) begin
            psel_reg <= hwdata[PW-1:0];
         end
         if (hit({24'h0, wa_reg}, A_MASK)) begin
            mask_reg <= hwdata[PW-1:0];
         end
      end
   end

   // Drive strength and bank output mode
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         drv_reg  <= RST_DRIVE;
         ocfg_reg <= RST_OUTCFG;
      end else if (wr) begin
         if (hit({24'h0, wa_reg}, A_DRIVE)) begin
            drv_reg <= hwdata;
         end
         if (hit({24'h0, wa_reg}, A_OUTCFG)) begin
            ocfg_reg <= hwdata[NB-1:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // Input port register and latch
   // ---------------------------------------------------------------
   // A latched bit freezes on its first change until a read;
   // a change arriving with the read loads in_reg directly, unheld
   always_comb begin
      for (int i = 0; i < PW; i++) begin
         if (lat_reg[i] && hold_reg[i] && !rd_in) begin
            in_next[i]   = in_reg[i];
            hold_next[i] = 1'b1;
         end else begin
            in_next[i]   = pin_s[i];
            hold_next[i] = lat_reg[i] & ~rd_in &
                           (pin_s[i] ^ in_reg[i]);
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         in_reg   <= RST_ZERO;
         hold_reg <= RST_ZERO;
      end else begin
         in_reg   <= in_next;
         hold_reg <= hold_next;
      end
   end

   // ---------------------------------------------------------------
   // Interrupt status
   // ---------------------------------------------------------------
   // Any pin that differs from its register bit is an event
   assign diff = pin_s ^ in_reg;

   // Sticky, unmasked only; write-one or input read clears,
   // and a new event in the clearing cycle wins
   always_comb begin
      sts_next = sts_reg;
      if (rd_in) begin
         sts_next = '0;
      end
      if (wr && hit({24'h0, wa_reg}, A_STATUS)) begin
         sts_next = sts_next & ~hwdata[PW-1:0];
      end
      sts_next = sts_next | (diff & ~mask_reg);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sts_reg <= RST_ZERO;
      end else begin
         sts_reg <= sts_next;
      end
   end

   // Masking later also hides an already set bit
   assign irq = |(sts_reg & ~mask_reg);

   // Open-drain, active low: enable pulls the line down
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         int_n_oe <= 1'b0;
      end else begin
         int_n_oe <= irq;
      end
   end
   assign int_n_o = 1'b0;

   // ---------------------------------------------------------------
   // Target address from straps
   // ---------------------------------------------------------------
   // Straps are caught once, after the synchroniser has filled;
   // later strap moves are ignored until the next reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         taddr_reg  <= '0;
         taddr_done <= 1'b0;
         fill_reg   <= '0;
      end else begin
         // Keep sampling until two edges have filled the strap pipe
         fill_reg   <= {fill_reg[0], 1'b1};
         taddr_done <= fill_reg[1];
         if (taddr_done == 1'b0) begin
            taddr_reg <= {TADDR_HI, strap_s};
         end
      end
   end

   // ---------------------------------------------------------------
   // Pad stage
   // ---------------------------------------------------------------
   assign pif.clk      = hclk;
   assign pif.rstn     = hresetn;
   assign pif.out_val  = out_reg;
   assign pif.dir_in   = cfg_reg;
   assign pif.pull_en  = pen_reg;
   assign pif.pull_sel = psel_reg;
   assign pif.od_bank  = ocfg_reg;
   assign pif.drive    = drv_reg;

   gpx_pad u_pad (
      .pc           (pif.pad),
      .port_o       (port_o),
      .port_oe      (port_oe),
      .port_pull_en (port_pull_en),
      .port_pull_up (port_pull_up),
      .port_drive   (port_drive)
   );

endmodule // gpx_top
